/* rtl/spc_pkg.sv */
// Package for the sector protection command host: codes, addresses, register map, timing
package spc_pkg;
   // Command codes issued on the flash data bus
   localparam logic [7:0] CODE_UNLOCK1   = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK2   = 8'h55;
   localparam logic [7:0] CODE_SET_LOCK  = 8'h40;
   localparam logic [7:0] CODE_SET_PERS  = 8'hC0;
   localparam logic [7:0] CODE_SET_FRZ   = 8'h50;
   localparam logic [7:0] CODE_SET_DYN   = 8'hE0;
   localparam logic [7:0] CODE_PROGRAM   = 8'hA0;
   localparam logic [7:0] CODE_ERASE1    = 8'h80;
   localparam logic [7:0] CODE_ERASE2    = 8'h30;
   localparam logic [7:0] CODE_EXIT1     = 8'h90;
   localparam logic [7:0] CODE_ZERO      = 8'h00;
   localparam logic [7:0] CODE_ONE       = 8'h01;
   // Unlock addresses, word and byte mode
   localparam logic [25:0] ADDR_W555     = 26'h0000555;
   localparam logic [25:0] ADDR_W2AA     = 26'h00002AA;
   localparam logic [25:0] ADDR_B_AAA    = 26'h0000AAA;
   localparam logic [25:0] ADDR_B555     = 26'h0000555;
   localparam logic [25:0] ADDR_ZERO     = 26'h0000000;
   // Software register map (word index on the local port)
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_ADDR       = 4'h1;
   localparam logic [3:0] REG_DATA       = 4'h2;
   localparam logic [3:0] REG_STATUS     = 4'h3;
   localparam logic [3:0] REG_RESULT     = 4'h4;
   // Control register fields
   localparam int CTRL_GO_BIT            = 0;
   localparam int CTRL_BYTE_BIT          = 1;
   localparam int CTRL_SET_LSB           = 4;
   localparam int CTRL_OP_LSB            = 8;
   // Timing: bus cycle phase lengths
   localparam int CLK_NS                 = 10;
   localparam int T_SETUP_NS             = 30;
   localparam int T_PULSE_NS             = 50;
   localparam int T_HOLD_NS              = 30;
   localparam int T_READ_NS              = 90;
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] READ_CYC  = 4'((T_READ_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [1:0] {SET_LOCK, SET_PERS, SET_FRZ, SET_DYN} spc_set_e;
   typedef enum logic [2:0] {OP_PROG, OP_CLEAR, OP_ERASE, OP_READ, OP_EXIT, OP_ENTER}
      spc_op_e;

   // One flash bus cycle handed to the pin driver
   typedef struct packed
   {
      logic        wr;
      logic [25:0] addr;
      logic [15:0] data;
   } spc_cyc_s;
endpackage

/* rtl/spc_buscyc.sv */
// Single asynchronous flash bus cycle driver (write pulse or timed read)
`timescale 1ns/1ps
`default_nettype none
module spc_buscyc
(
   // Clock and reset
   input  wire  logic                 clk,
   input  wire  logic                 rst_n,
   // Cycle request
   input  wire  logic                 start,
   input  wire  spc_pkg::spc_cyc_s    cyc,
   output logic                       done,
   output logic [15:0]                rdata,
   // Flash pins (registered)
   output logic [25:0]                f_addr,
   output logic [15:0]                f_dq_out,
   output logic                       f_dq_oe,
   input  wire  logic [15:0]          f_dq_in,
   output logic                       f_ce_n,
   output logic                       f_we_n,
   output logic                       f_oe_n
);
   typedef enum logic [1:0] {IDLE, SETUP, PULSE, HOLD} spc_ph_e;
   spc_ph_e     ph_reg;
   logic [3:0]  cnt_reg;
   logic        wr_reg;
   logic [15:0] dq_s1_reg;
   logic [15:0] dq_s2_reg;

   // Data pins come from outside the clock domain
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         dq_s1_reg <= 16'h0000;
         dq_s2_reg <= 16'h0000;
      end
      else
      begin
         dq_s1_reg <= f_dq_in;
         dq_s2_reg <= dq_s1_reg;
      end

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         ph_reg   <= IDLE;
         cnt_reg  <= 4'h0;
         wr_reg   <= 1'b0;
         done     <= 1'b0;
         rdata    <= 16'h0000;
         f_addr   <= 26'h0000000;
         f_dq_out <= 16'h0000;
         f_dq_oe  <= 1'b0;
         f_ce_n   <= 1'b1;
         f_we_n   <= 1'b1;
         f_oe_n   <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         case (ph_reg)
            IDLE:
               if (start)
               begin
                  wr_reg   <= cyc.wr;
                  f_addr   <= cyc.addr;
                  f_dq_out <= cyc.data;
                  f_dq_oe  <= cyc.wr;
                  f_ce_n   <= 1'b0;
                  cnt_reg  <= spc_pkg::SETUP_CYC;
                  ph_reg   <= SETUP;
               end
            SETUP:
               if (cnt_reg <= 4'h1)
               begin
                  f_we_n  <= !wr_reg;
                  f_oe_n  <= wr_reg;
                  // Two extra cycles cover the read synchroniser latency
                  cnt_reg <= wr_reg ? spc_pkg::PULSE_CYC : spc_pkg::READ_CYC + 4'h2;
                  ph_reg  <= PULSE;
               end
               else
                  cnt_reg <= cnt_reg - 4'h1;
            PULSE:
               if (cnt_reg <= 4'h1)
               begin
                  rdata   <= dq_s2_reg;
                  f_we_n  <= 1'b1;
                  f_oe_n  <= 1'b1;
                  cnt_reg <= spc_pkg::HOLD_CYC;
                  ph_reg  <= HOLD;
               end
               else
                  cnt_reg <= cnt_reg - 4'h1;
            HOLD:
               if (cnt_reg <= 4'h1)
               begin
                  f_ce_n  <= 1'b1;
                  f_dq_oe <= 1'b0;
                  done    <= 1'b1;
                  ph_reg  <= IDLE;
               end
               else
                  cnt_reg <= cnt_reg - 4'h1;
            default:
               ph_reg <= IDLE;
         endcase
      end
endmodule
`default_nettype wire

/* rtl/spc_host.sv */
// Host controller issuing sector protection command sequences to a parallel flash
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module spc_host
(
   // Clock and reset
   input  wire  logic           MCLK,
   input  wire  logic           RST_N,
   // Software register port
   input  wire  logic [3:0]     REG_ADDR,
   input  wire  logic [31:0]    REG_WDATA,
   input  wire  logic           REG_WR,
   input  wire  logic           REG_RD,
   output logic [31:0]          REG_RDATA,
   // Flash pins
   output logic [25:0]          F_ADDR,
   output logic [15:0]          F_DQ_OUT,
   output logic                 F_DQ_OE,
   input  wire  logic [15:0]    F_DQ_IN,
   output logic                 F_CE_N,
   output logic                 F_WE_N,
   output logic                 F_OE_N
);
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} spc_st_e;
   spc_st_e             st_reg;
   spc_pkg::spc_set_e   set_reg;
   spc_pkg::spc_op_e    op_reg;
   logic                byte_reg;
   logic [25:0]         addr_reg;
   logic [15:0]         data_reg;
   logic [15:0]         result_reg;
   logic [2:0]          step_reg;
   logic [2:0]          nsteps;
   logic                busy_reg;
   logic                err_reg;
   logic                active_reg;
   spc_pkg::spc_set_e   act_set_reg;
   logic                start_reg;
   spc_pkg::spc_cyc_s   cyc_reg;
   spc_pkg::spc_cyc_s   cyc_next;
   logic                cyc_done;
   logic [15:0]         cyc_rdata;
   logic                go;
   logic                legal;
   logic [7:0]          set_code;

   assign go = REG_WR && REG_ADDR == spc_pkg::REG_CTRL && REG_WDATA[spc_pkg::CTRL_GO_BIT];

   // Pick the set entry code for the requested set
   always_comb
   begin
      case (set_reg)
         spc_pkg::SET_LOCK: set_code = spc_pkg::CODE_SET_LOCK;
         spc_pkg::SET_PERS: set_code = spc_pkg::CODE_SET_PERS;
         spc_pkg::SET_FRZ:  set_code = spc_pkg::CODE_SET_FRZ;
         default:           set_code = spc_pkg::CODE_SET_DYN;
      endcase
   end

   // Set entry is sent only while no set is active, other operations only if defined for the active set; all else is refused
   always_comb
   begin
      legal = 1'b0;
      case (op_reg)
         spc_pkg::OP_ENTER: legal = !active_reg;
         spc_pkg::OP_EXIT:  legal = active_reg;
         spc_pkg::OP_PROG:  legal = active_reg;
         spc_pkg::OP_CLEAR: legal = active_reg && act_set_reg == spc_pkg::SET_DYN;
         spc_pkg::OP_ERASE: legal = active_reg && act_set_reg == spc_pkg::SET_PERS;
         spc_pkg::OP_READ:  legal = active_reg;
         default:           legal = 1'b0;
      endcase
   end

   // Number of bus cycles per operation
   always_comb
   begin
      case (op_reg)
         spc_pkg::OP_ENTER: nsteps = 3'd3;
         spc_pkg::OP_READ:  nsteps = 3'd1;
         default:           nsteps = 3'd2;
      endcase
   end

   // Bus cycle for the current step
   always_comb
   begin
      cyc_next = '{wr: 1'b1, addr: spc_pkg::ADDR_ZERO, data: 16'h0000};
      case (op_reg)
         spc_pkg::OP_ENTER:
            case (step_reg)
               3'd0: cyc_next = '{1'b1, byte_reg ? spc_pkg::ADDR_B_AAA : spc_pkg::ADDR_W555,
                                  {8'h00, spc_pkg::CODE_UNLOCK1}};
               3'd1: cyc_next = '{1'b1, byte_reg ? spc_pkg::ADDR_B555 : spc_pkg::ADDR_W2AA,
                                  {8'h00, spc_pkg::CODE_UNLOCK2}};
               default: cyc_next = '{1'b1, byte_reg ? spc_pkg::ADDR_B_AAA : spc_pkg::ADDR_W555,
                                     {8'h00, set_code}};
            endcase
         spc_pkg::OP_PROG:
            if (step_reg == 3'd0)
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_PROGRAM}};
            else if (act_set_reg == spc_pkg::SET_LOCK)
               cyc_next = '{1'b1, addr_reg, data_reg};
            else
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_ZERO}};
         spc_pkg::OP_CLEAR:
            if (step_reg == 3'd0)
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_PROGRAM}};
            else
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_ONE}};
         spc_pkg::OP_ERASE:
            if (step_reg == 3'd0)
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_ERASE1}};
            else
               cyc_next = '{1'b1, spc_pkg::ADDR_ZERO, {8'h00, spc_pkg::CODE_ERASE2}};
         spc_pkg::OP_READ:
            cyc_next = '{1'b0, addr_reg, 16'h0000};
         spc_pkg::OP_EXIT:
            if (step_reg == 3'd0)
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_EXIT1}};
            else
               cyc_next = '{1'b1, addr_reg, {8'h00, spc_pkg::CODE_ZERO}};
         default:
            cyc_next = '{1'b1, spc_pkg::ADDR_ZERO, 16'h0000};
      endcase
   end

   // Software-written operands
   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
      begin
         addr_reg <= 26'h0000000;
         data_reg <= 16'h0000;
         byte_reg <= 1'b0;
         set_reg  <= spc_pkg::SET_LOCK;
         op_reg   <= spc_pkg::OP_ENTER;
      end
      else if (REG_WR && !busy_reg)
      begin
         if (REG_ADDR == spc_pkg::REG_ADDR)
            addr_reg <= REG_WDATA[25:0];
         if (REG_ADDR == spc_pkg::REG_DATA)
            data_reg <= REG_WDATA[15:0];
         if (REG_ADDR == spc_pkg::REG_CTRL)
         begin
            byte_reg <= REG_WDATA[spc_pkg::CTRL_BYTE_BIT];
            set_reg  <= spc_pkg::spc_set_e'(REG_WDATA[spc_pkg::CTRL_SET_LSB +: 2]);
            op_reg   <= spc_pkg::spc_op_e'(REG_WDATA[spc_pkg::CTRL_OP_LSB +: 3]);
         end
      end

   // Sequencer; operands are latched one cycle before S_ISSUE reads them
   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
      begin
         st_reg      <= S_IDLE;
         step_reg    <= 3'd0;
         busy_reg    <= 1'b0;
         err_reg     <= 1'b0;
         active_reg  <= 1'b0;
         act_set_reg <= spc_pkg::SET_LOCK;
         start_reg   <= 1'b0;
         cyc_reg     <= '0;
         result_reg  <= 16'h0000;
      end
      else
      begin
         start_reg <= 1'b0;
         case (st_reg)
            S_IDLE:
               if (go && !busy_reg)
               begin
                  busy_reg <= 1'b1;
                  step_reg <= 3'd0;
                  st_reg   <= S_ISSUE;
               end
            S_ISSUE:
               if (!legal)
               begin
                  err_reg  <= 1'b1;
                  busy_reg <= 1'b0;
                  st_reg   <= S_IDLE;
               end
               else
               begin
                  err_reg   <= 1'b0;
                  cyc_reg   <= cyc_next;
                  start_reg <= 1'b1;
                  st_reg    <= S_WAIT;
               end
            S_WAIT:
               if (cyc_done)
               begin
                  if (!cyc_reg.wr)
                     result_reg <= cyc_rdata;
                  if (step_reg + 3'd1 >= nsteps)
                  begin
                     if (op_reg == spc_pkg::OP_ENTER)
                     begin
                        active_reg  <= 1'b1;
                        act_set_reg <= set_reg;
                     end
                     if (op_reg == spc_pkg::OP_EXIT)
                        active_reg <= 1'b0;
                     busy_reg <= 1'b0;
                     st_reg   <= S_IDLE;
                  end
                  else
                  begin
                     step_reg <= step_reg + 3'd1;
                     st_reg   <= S_ISSUE;
                  end
               end
            default:
               st_reg <= S_IDLE;
         endcase
      end

   // Read data one cycle after the strobe
   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
         REG_RDATA <= 32'h00000000;
      else if (REG_RD)
         case (REG_ADDR)
            spc_pkg::REG_ADDR:   REG_RDATA <= {6'h00, addr_reg};
            spc_pkg::REG_DATA:   REG_RDATA <= {16'h0000, data_reg};
            spc_pkg::REG_STATUS: REG_RDATA <= {26'h0000000, act_set_reg, 1'b0, active_reg,
                                               err_reg, busy_reg};
            // Status reads of freeze or dynamic bits: bit 0 set means unprotected
            spc_pkg::REG_RESULT: REG_RDATA <= {16'h0000, result_reg};
            default:             REG_RDATA <= 32'h00000000;
         endcase
      else
         REG_RDATA <= 32'h00000000;

   spc_buscyc u_cyc
   (
      .clk      (MCLK),
      .rst_n    (RST_N),
      .start    (start_reg),
      .cyc      (cyc_reg),
      .done     (cyc_done),
      .rdata    (cyc_rdata),
      .f_addr   (F_ADDR),
      .f_dq_out (F_DQ_OUT),
      .f_dq_oe  (F_DQ_OE),
      .f_dq_in  (F_DQ_IN),
      .f_ce_n   (F_CE_N),
      .f_we_n   (F_WE_N),
      .f_oe_n   (F_OE_N)
   );
endmodule
`default_nettype wire

/* test/spc_host_asserts.sv */
// Pin timing and register port checks for the protection command host
`timescale 1ns/1ps
`default_nettype none
module spc_host_asserts
(
   // Clock and reset
   input wire logic        MCLK,
   input wire logic        RST_N,
   // Register port
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   // Flash pins
   input wire logic [25:0] F_ADDR,
   input wire logic [15:0] F_DQ_OUT,
   input wire logic        F_DQ_OE,
   input wire logic        F_CE_N,
   input wire logic        F_WE_N,
   input wire logic        F_OE_N
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_pulse;
      !F_WE_N [*5] ##1 F_WE_N;
   endsequence
   sequence s_hold;
      ($stable(F_ADDR) && $stable(F_DQ_OUT) && F_DQ_OE && !F_CE_N) [*3] ##1 F_CE_N;
   endsequence
   sequence s_read;
      (!F_OE_N && !F_DQ_OE && !F_CE_N) [*8] ##1 !F_OE_N [*3] ##1 F_OE_N;
   endsequence
   a_we_pulse: assert property ($fell(F_WE_N) |-> s_pulse)
      else $error("write pulse length wrong");
   a_we_setup: assert property ($fell(F_WE_N) |-> $past(F_CE_N, 3) == 1'b0)
      else $error("select setup before write pulse too short");
   a_we_hold: assert property ($rose(F_WE_N) |-> s_hold)
      else $error("address or data not held after write pulse");
   a_we_stable: assert property (!F_WE_N |-> $stable(F_ADDR) && $stable(F_DQ_OUT))
      else $error("address or data moved during write pulse");
   a_we_drives: assert property (!F_WE_N |-> F_DQ_OE && !F_CE_N && F_OE_N)
      else $error("write pulse without driven data");
   a_read_window: assert property ($fell(F_OE_N) |-> s_read)
      else $error("read window length wrong");
   a_idle_pins: assert property (F_CE_N |-> F_WE_N && F_OE_N && !F_DQ_OE)
      else $error("strobe or drive while deselected");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data outside its cycle");
endmodule
bind spc_host spc_host_asserts u_spc_host_asserts (.MCLK(MCLK), .RST_N(RST_N), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .F_ADDR(F_ADDR), .F_DQ_OUT(F_DQ_OUT), .F_DQ_OE(F_DQ_OE),
   .F_CE_N(F_CE_N), .F_WE_N(F_WE_N), .F_OE_N(F_OE_N));
`default_nettype wire

/* test/spc_flash_model.sv */
// Behavioural flash device answering the protection command sets
`timescale 1ns/1ps
`default_nettype none
module spc_flash_model
(
   // Flash pins
   input wire logic [25:0] F_ADDR,
   input wire logic [15:0] DQ,
   input wire logic        F_CE_N,
   input wire logic        F_WE_N,
   input wire logic        F_OE_N,
   // Scenario controls
   input wire logic        BYTE_MODE,
   input wire logic        SLOW,
   output logic [15:0]     DQ_DRV
);
   logic [25:0]   wa[$];
   logic [15:0]   wd[$];
   logic [1023:0] pers_q = '0;
   logic [1023:0] dyn_q = '0;
   logic [15:0]   lock_q = 16'hFFFF;
   logic [15:0]   rd_v;
   logic [15:0]   last_q = 16'h0;
   logic [7:0]    set_q = 8'h00;
   logic [7:0]    pend_q = 8'h00;
   logic [7:0]    d;
   logic          frz_q = 1'b0;
   logic          ok = 1'b0;
   wire  [9:0]    sec = F_ADDR[25:16];
   wire  [25:0]   u1 = BYTE_MODE ? 26'hAAA : 26'h555;
   wire  [25:0]   u2 = BYTE_MODE ? 26'h555 : 26'h2AA;
   always @(posedge F_WE_N)
      if (!F_CE_N)
      begin
         d = DQ[7:0];
         if (set_q == 8'h00)
         begin
            if (wa.size() > 1 && wa[$-1] == u1 && wd[$-1] == 16'hAA && wa[$] == u2
                && wd[$] == 16'h55 && F_ADDR == u1 && d inside {8'h40, 8'hC0, 8'h50, 8'hE0})
               set_q = d;
         end
         else if (pend_q == 8'hA0)
         begin
            if (set_q == 8'h40) lock_q = DQ;
            if (set_q == 8'hC0 && d == 8'h00) pers_q[sec] = 1'b1;
            if (set_q == 8'h50 && d == 8'h00) frz_q = 1'b1;
            if (set_q == 8'hE0 && d < 8'h02) dyn_q[sec] = ~d[0];
            pend_q = 8'h00;
         end
         else if (pend_q == 8'h80)
         begin
            if (d == 8'h30 && F_ADDR == 26'h0) pers_q = '0;
            pend_q = 8'h00;
         end
         else if (pend_q == 8'h90)
         begin
            if (d == 8'h00) set_q = 8'h00;
            pend_q = 8'h00;
         end
         else if (d inside {8'hA0, 8'h90} || (d == 8'h80 && set_q == 8'hC0))
            pend_q = d;
         wa.push_back(F_ADDR);
         wd.push_back(DQ);
      end
   // Status sits on the low data lines, 00 protected, 01 unprotected
   always @*
      case (set_q)
         8'h40: rd_v = lock_q;
         8'hC0: rd_v = {15'h0, ~pers_q[sec]};
         8'h50: rd_v = {15'h0, ~frz_q};
         8'hE0: rd_v = {15'h0, ~dyn_q[sec]};
         default: rd_v = ~last_q;
      endcase
   always @(negedge F_OE_N)
   begin
      ok = 1'b0;
      #(SLOW ? 60 : 5) ok = !F_OE_N;
   end
   always @(posedge F_OE_N) last_q = rd_v;
   // Released bus shows the inverse so a stale sample cannot pass
   assign DQ_DRV = (ok && !F_CE_N && !F_OE_N) ? rd_v : ~last_q;
endmodule
`default_nettype wire

/* test/spc_host_tb_top.sv */
// Self-checking bench for the protection command host
`timescale 1ns/1ps
`default_nettype none
module spc_host_tb_top;
   logic        MCLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   logic        bmode = 1'b0, slow = 1'b0, F_DQ_OE, F_CE_N, F_WE_N, F_OE_N;
   logic [3:0]  REG_ADDR = 4'h0;
   logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rd, r, seed = 32'h36;
   logic [25:0] F_ADDR, sa = 26'h0;
   logic [15:0] F_DQ_OUT, dq_drv, dat = 16'h0;
   logic [1:0]  cur = 2'h0;
   logic [7:0]  codes[4] = '{8'h40, 8'hC0, 8'h50, 8'hE0};
   wire  [15:0] dq = F_DQ_OE ? F_DQ_OUT : dq_drv;
   int          errors = 0, n_compared = 0, cyc = 0;
   always #5 MCLK = ~MCLK;
   spc_host u_spc_host (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .F_ADDR(F_ADDR),
      .F_DQ_OUT(F_DQ_OUT), .F_DQ_OE(F_DQ_OE), .F_DQ_IN(dq), .F_CE_N(F_CE_N),
      .F_WE_N(F_WE_N), .F_OE_N(F_OE_N));
   spc_flash_model u_spc_flash_model (.F_ADDR(F_ADDR), .DQ(dq), .F_CE_N(F_CE_N),
      .F_WE_N(F_WE_N), .F_OE_N(F_OE_N), .BYTE_MODE(bmode), .SLOW(slow), .DQ_DRV(dq_drv));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic close_out();
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bit 26 of the expected address marks an address that matters
   task automatic cmp_cyc(input logic [26:0] ea, input logic [15:0] ed);
      logic [41:0] g;
      g = 'x;
      if (u_spc_flash_model.wa.size() > 0)
         g = {u_spc_flash_model.wa.pop_front(), u_spc_flash_model.wd.pop_front()};
      if (!ea[26])
         g[41:16] = ea[25:0];
      cmp_reg({6'h0, g[41:16]} ^ {16'h0, g[15:0]}, {6'h0, ea[25:0]} ^ {16'h0, ed});
      cmp_reg({16'h0, g[15:0]}, {16'h0, ed});
   endtask
   task automatic pair(input logic [15:0] d1, input logic [26:0] a2, input logic [15:0] d2);
      cmp_cyc(27'h0, d1);
      cmp_cyc(a2, d2);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge MCLK);
      REG_WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(posedge MCLK);
      d = REG_RDATA;
   endtask
   task automatic go(input logic [2:0] op);
      int n;
      cmp_reg(32'(u_spc_flash_model.wa.size()), 32'h0);
      wr(spc_pkg::REG_ADDR, {6'h0, sa});
      wr(spc_pkg::REG_DATA, {16'h0, dat});
      wr(spc_pkg::REG_CTRL, {21'h0, op, 2'h0, cur, 2'h0, bmode, 1'b1});
      n = 0;
      rd = 32'h1;
      while (rd[0] !== 1'b0 && n < 100)
      begin
         rd_reg(spc_pkg::REG_STATUS, rd);
         n++;
      end
      cmp_reg({31'h0, rd[0]}, 32'h0);
   endtask
   task automatic rdchk(input logic [15:0] exp);
      go(3'h3);
      rd_reg(spc_pkg::REG_RESULT, rd);
      cmp_reg({16'h0, rd[15:0]}, {16'h0, exp});
   endtask
   always @(posedge MCLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         close_out();
      end
   end
   initial
   begin
      repeat (10) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      cmp_reg({28'h0, F_CE_N, F_WE_N, F_OE_N, F_DQ_OE}, 32'hE);
      rd_reg(4'hF, rd);
      cmp_reg(rd, 32'h0);
      go(3'h0);
      cmp_reg({31'h0, rd[1]}, 32'h1);
      for (int s = 0; s < 4; s++)
      begin
         r = rnd();
         bmode <= s[0];
         slow <= s[1];
         cur <= s[1:0];
         @(posedge MCLK);
         sa = {r[9:0], 16'h0};
         dat = (s == 0) ? r[31:16] : 16'h0;
         go(3'h5);
         cmp_cyc({1'b1, bmode ? spc_pkg::ADDR_B_AAA : spc_pkg::ADDR_W555}, 16'hAA);
         cmp_cyc({1'b1, bmode ? spc_pkg::ADDR_B555 : spc_pkg::ADDR_W2AA}, 16'h55);
         cmp_cyc({1'b1, bmode ? spc_pkg::ADDR_B_AAA : spc_pkg::ADDR_W555}, {8'h0, codes[s]});
         cmp_reg({29'h0, rd[5:4], rd[2]}, {29'h0, cur, 1'b1});
         if (s == 0)
         begin
            go(3'h0);
            pair(16'hA0, 27'h0, dat);
            rdchk(dat);
         end
         if (s == 1)
         begin
            go(3'h0);
            pair(16'hA0, {1'b1, sa}, 16'h0);
            rdchk(16'h0);
            go(3'h2);
            pair(16'h80, {1'b1, 26'h0}, 16'h30);
            rdchk(16'h1);
            go(3'h5);
            cmp_reg({31'h0, rd[1]}, 32'h1);
         end
         if (s == 2)
         begin
            rdchk(16'h1);
            go(3'h0);
            pair(16'hA0, 27'h0, 16'h0);
            rdchk(16'h0);
         end
         if (s == 3)
         begin
            go(3'h0);
            pair(16'hA0, {1'b1, sa}, 16'h0);
            rdchk(16'h0);
            go(3'h1);
            pair(16'hA0, {1'b1, sa}, 16'h1);
            rdchk(16'h1);
            go(3'h2);
            cmp_reg({31'h0, rd[1]}, 32'h1);
         end
         go(3'h4);
         pair(16'h90, 27'h0, 16'h0);
         cmp_reg({31'h0, rd[2]}, 32'h0);
      end
      go(3'h3);
      cmp_reg({31'h0, rd[1]}, 32'h1);
      close_out();
   end
endmodule
`default_nettype wire
